// ===== tmcap_top.sv
// Sixteen-bit timer counter, prescaler, overflow flag and two capture channels.
// Assumes a byte register port with read data one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
module tmcap_top #(
	parameter bit REDUCED = 1'b0,
	parameter bit EXT_BONDED = 1'b1,
	parameter bit CAP2_BONDED = 1'b1
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_halt,
	input wire logic i_global_mask,
	input wire logic i_ext_count_pin,
	input wire logic i_capture_pin_1,
	input wire logic i_capture_pin_2,
	output logic o_timer_irq,
	output logic [15:0] o_counter_value
);
	logic [7:0] ctrl_one_q;
	logic [7:0] ctrl_two_q;
	logic [15:0] count_q;
	logic [2:0] presc_q;
	logic [7:0] lo_buf_q;
	logic buf_held_q;
	logic ovf_flag_q;
	logic ovf_armed_q;
	logic [7:0] rdata_q;
	logic ext_edge;
	logic cap1_edge;
	logic cap2_edge;
	logic [15:0] cap1_value;
	logic [15:0] cap2_value;
	logic cap1_flag;
	logic cap2_flag_raw;
	logic cap2_flag;
	logic tick;
	logic run;
	logic cnt_lo_wr;
	logic cnt_lo_acc;
	logic flags_rd;
	logic pwm_or_pulse;
	logic [1:0] clk_sel;
	logic [2:0] presc_mask;
	logic ext_pin;
	logic cap2_pin;

	// ==========================================
	// Address decode helpers
	function automatic logic hit(input logic [3:0] a, input logic [3:0] want, input logic s);
		hit = s & (a == want);
	endfunction

	function automatic logic is_cnt_hi(input logic [3:0] a);
		is_cnt_hi = (a == tmcap_pkg::ADDR_CNT_HI) | (a == tmcap_pkg::ADDR_ALT_HI);
	endfunction

	function automatic logic is_cnt_lo(input logic [3:0] a);
		is_cnt_lo = (a == tmcap_pkg::ADDR_CNT_LO) | (a == tmcap_pkg::ADDR_ALT_LO);
	endfunction

	assign clk_sel = ctrl_two_q[tmcap_pkg::CTL2_CLK_SEL_LO +: 2];
	assign pwm_or_pulse = ctrl_two_q[tmcap_pkg::CTL2_PWM] | ctrl_two_q[tmcap_pkg::CTL2_SINGLE_PULSE];
	assign run = i_clk_en & ~i_halt;
	assign flags_rd = hit(i_addr, tmcap_pkg::ADDR_FLAGS, i_rd);
	assign cnt_lo_wr = i_wr & is_cnt_lo(i_addr);
	assign cnt_lo_acc = hit(i_addr, tmcap_pkg::ADDR_CNT_LO, i_rd | i_wr);
	assign ext_pin = EXT_BONDED ? i_ext_count_pin : 1'b1;
	assign cap2_pin = CAP2_BONDED ? i_capture_pin_2 : 1'b1;

	// ==========================================
	// Pin synchronisers
	tmcap_sync_edge u_ext_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_clk_en(run),
		.i_pin(ext_pin),
		.i_rise_sel(ctrl_two_q[tmcap_pkg::CTL2_EXT_EDGE]),
		.o_edge(ext_edge)
	);

	tmcap_sync_edge u_cap1_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_pin(i_capture_pin_1),
		.i_rise_sel(ctrl_one_q[tmcap_pkg::CTL1_EDGE_POL]),
		.o_edge(cap1_edge)
	);

	tmcap_sync_edge u_cap2_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_pin(cap2_pin),
		.i_rise_sel(ctrl_two_q[tmcap_pkg::CTL2_EDGE_POL]),
		.o_edge(cap2_edge)
	);

	// ==========================================
	// Control registers
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_one_q <= tmcap_pkg::CTRL_RESET;
		end else if (i_clk_en && hit(i_addr, tmcap_pkg::ADDR_CTRL_ONE, i_wr)) begin
			ctrl_one_q <= i_wdata;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_two_q <= tmcap_pkg::CTRL_RESET;
		end else if (i_clk_en && hit(i_addr, tmcap_pkg::ADDR_CTRL_TWO, i_wr)) begin
			ctrl_two_q <= i_wdata;
		end
	end

	// ==========================================
	// Prescaler and tick
	always_comb begin
		case (clk_sel)
			tmcap_pkg::CLK_DIV2: presc_mask = tmcap_pkg::PRESC_MASK_DIV2;
			tmcap_pkg::CLK_DIV4: presc_mask = tmcap_pkg::PRESC_MASK_DIV4;
			tmcap_pkg::CLK_DIV8: presc_mask = tmcap_pkg::PRESC_MASK_DIV8;
			default: presc_mask = tmcap_pkg::PRESC_MASK_DIV8;
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			presc_q <= 3'h0;
		end else if (run) begin
			presc_q <= 3'(presc_q + 3'h1);
		end
	end

	assign tick = (clk_sel == tmcap_pkg::CLK_EXT) ? ext_edge
		: ((presc_q & presc_mask) == presc_mask);

	// ==========================================
	// Free-running counter
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_q <= tmcap_pkg::COUNT_RELOAD;
		end else if (i_clk_en) begin
			if (cnt_lo_wr) begin
				count_q <= tmcap_pkg::COUNT_RELOAD;
			end else if (run && tick) begin
				count_q <= 16'(count_q + 16'h0001);
			end
		end
	end

	// ==========================================
	// Low byte buffer for 16-bit reads
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lo_buf_q <= 8'h00;
			buf_held_q <= 1'b0;
		end else if (i_clk_en && i_rd) begin
			if (is_cnt_hi(i_addr) && !buf_held_q) begin
				lo_buf_q <= count_q[7:0];
				buf_held_q <= 1'b1;
			end else if (is_cnt_lo(i_addr)) begin
				buf_held_q <= 1'b0;
			end
		end
	end

	// ==========================================
	// Overflow flag, two-step clear, set wins
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ovf_flag_q <= 1'b0;
			ovf_armed_q <= 1'b0;
		end else if (i_clk_en) begin
			if (run && tick && !cnt_lo_wr && count_q == tmcap_pkg::COUNT_MAX) begin
				ovf_flag_q <= 1'b1;
			end else if (ovf_armed_q && cnt_lo_acc) begin
				ovf_flag_q <= 1'b0;
			end
			if (flags_rd) begin
				ovf_armed_q <= ovf_flag_q;
			end else if (cnt_lo_acc) begin
				ovf_armed_q <= 1'b0;
			end
		end
	end

	// ==========================================
	// Capture channels
	tmcap_capture u_cap1 (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_enable(~pwm_or_pulse),
		.i_edge(cap1_edge),
		.i_count(count_q),
		.i_hi_rd(hit(i_addr, tmcap_pkg::ADDR_CAP1_HI, i_rd)),
		.i_lo_rd(hit(i_addr, tmcap_pkg::ADDR_CAP1_LO, i_rd)),
		.i_lo_acc(hit(i_addr, tmcap_pkg::ADDR_CAP1_LO, i_rd | i_wr)),
		.i_flags_rd(flags_rd),
		.o_value(cap1_value),
		.o_flag(cap1_flag)
	);

	tmcap_capture u_cap2 (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_enable(~REDUCED),
		.i_edge(cap2_edge),
		.i_count(count_q),
		.i_hi_rd(hit(i_addr, tmcap_pkg::ADDR_CAP2_HI, i_rd)),
		.i_lo_rd(hit(i_addr, tmcap_pkg::ADDR_CAP2_LO, i_rd)),
		.i_lo_acc(hit(i_addr, tmcap_pkg::ADDR_CAP2_LO, i_rd | i_wr)),
		.i_flags_rd(flags_rd),
		.o_value(cap2_value),
		.o_flag(cap2_flag_raw)
	);

	assign cap2_flag = cap2_flag_raw & ~REDUCED;

	// ==========================================
	// Read data, one cycle after the strobe
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_q <= 8'h00;
		end else if (i_clk_en) begin
			if (!i_rd) begin
				rdata_q <= 8'h00;
			end else begin
				case (i_addr)
					tmcap_pkg::ADDR_CTRL_ONE: rdata_q <= ctrl_one_q;
					tmcap_pkg::ADDR_CTRL_TWO: rdata_q <= ctrl_two_q;
					tmcap_pkg::ADDR_FLAGS: begin
						rdata_q <= 8'h00;
						rdata_q[tmcap_pkg::FLG_CAP1] <= cap1_flag;
						rdata_q[tmcap_pkg::FLG_OVF] <= ovf_flag_q;
						rdata_q[tmcap_pkg::FLG_CAP2] <= cap2_flag;
					end
					tmcap_pkg::ADDR_CNT_HI,
					tmcap_pkg::ADDR_ALT_HI: rdata_q <= count_q[15:8];
					tmcap_pkg::ADDR_CNT_LO,
					tmcap_pkg::ADDR_ALT_LO: rdata_q <= buf_held_q ? lo_buf_q : count_q[7:0];
					tmcap_pkg::ADDR_CAP1_HI: rdata_q <= cap1_value[15:8];
					tmcap_pkg::ADDR_CAP1_LO: rdata_q <= cap1_value[7:0];
					tmcap_pkg::ADDR_CAP2_HI: rdata_q <= REDUCED ? 8'h00 : cap2_value[15:8];
					tmcap_pkg::ADDR_CAP2_LO: rdata_q <= REDUCED ? 8'h00 : cap2_value[7:0];
					default: rdata_q <= 8'h00;
				endcase
			end
		end
	end

	assign o_rdata = rdata_q;
	assign o_counter_value = count_q;

	// Timer request: any enabled pending flag while the global mask is clear
	assign o_timer_irq = ~i_global_mask &
		((ovf_flag_q & ctrl_one_q[tmcap_pkg::CTL1_OVF_IRQ_EN]) |
		((cap1_flag | cap2_flag) & ctrl_one_q[tmcap_pkg::CTL1_CAP_IRQ_EN]));
endmodule
`default_nettype wire

// ===== tmcap_pkg.sv
// Constants, offsets and field layouts for the timer counter and input capture block.
// Assumes a byte-wide register port driven on the rising edge of i_ref_clk.
//
// Functional notes
// - Sixteen-bit free-running up-counter, read as high and low bytes.
// - Counter ticks at CPU clock over 2, 4 or 8 per clock select.
// - Clock select both ones counts external pin edges of chosen polarity.
// - External edges are synchronised and counted on the CPU clock.
// - Counter loads FFFC at reset and on any low-byte count write.
// - Two count views; alternate low byte read never clears overflow flag.
// - High-byte read snapshots low byte; held until low byte is read.
// - After a finished sequence, lone low-byte read returns live low byte.
// - Overflow flag sets when counter wraps from FFFF to 0000.
// - Overflow request only with its enable set and global mask clear.
// - Overflow flag clears after status read then primary low-byte access.
// - Counter runs in wait, freezes in halt, resumes held count on wake.
// - Unbonded timer input pins read as constant one.
// - Active capture edge copies count into capture value and sets flag.
// - Channel one polarity in control one, channel two in control two.
// - Shared capture enable gates both capture flags onto the request.
// - Capture flag clears after status read then capture low-byte access.
// - Capture high-byte read blocks capture and flag until low byte read.
// - Capture register holds most recent capture; channels work independently.
// - In single pulse or PWM mode only channel two captures.
// - Capture pins feed capture logic whatever their port direction.
// - Reduced instance: channel two absent, its flag and capture value read zero.
package tmcap_pkg;
	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [3:0] ADDR_CTRL_TWO = 4'h1;
	localparam logic [3:0] ADDR_CTRL_ONE = 4'h2;
	localparam logic [3:0] ADDR_FLAGS = 4'h3;
	localparam logic [3:0] ADDR_CAP1_HI = 4'h4;
	localparam logic [3:0] ADDR_CAP1_LO = 4'h5;
	localparam logic [3:0] ADDR_CNT_HI = 4'h8;
	localparam logic [3:0] ADDR_CNT_LO = 4'h9;
	localparam logic [3:0] ADDR_ALT_HI = 4'hA;
	localparam logic [3:0] ADDR_ALT_LO = 4'hB;
	localparam logic [3:0] ADDR_CAP2_HI = 4'hC;
	localparam logic [3:0] ADDR_CAP2_LO = 4'hD;
	// ==========================================
	// Field positions
	localparam int CTL1_CAP_IRQ_EN = 7;
	localparam int CTL1_OVF_IRQ_EN = 5;
	localparam int CTL1_EDGE_POL = 1;
	localparam int CTL2_PWM = 4;
	localparam int CTL2_SINGLE_PULSE = 5;
	localparam int CTL2_CLK_SEL_LO = 2;
	localparam int CTL2_EDGE_POL = 1;
	localparam int CTL2_EXT_EDGE = 0;
	localparam int FLG_CAP1 = 7;
	localparam int FLG_OVF = 5;
	localparam int FLG_CAP2 = 4;
	// ==========================================
	// Reset values and count limit
	localparam logic [15:0] COUNT_RELOAD = 16'hFFFC;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] CAP_RESET = 16'h0000;
	// ==========================================
	// Clock select codes
	localparam logic [1:0] CLK_DIV2 = 2'b00;
	localparam logic [1:0] CLK_DIV4 = 2'b01;
	localparam logic [1:0] CLK_DIV8 = 2'b10;
	localparam logic [1:0] CLK_EXT = 2'b11;
	localparam logic [2:0] PRESC_MASK_DIV2 = 3'h1;
	localparam logic [2:0] PRESC_MASK_DIV4 = 3'h3;
	localparam logic [2:0] PRESC_MASK_DIV8 = 3'h7;
endpackage

// ===== tmcap_sync_edge.sv
// Two-flop synchroniser with edge detection for one pin.
// Assumes the pin is asynchronous to i_ref_clk.
`timescale 1ns/100ps
`default_nettype none
module tmcap_sync_edge (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic i_pin,
	input wire logic i_rise_sel,
	output logic o_edge
);
	logic meta_q;
	logic sync_q;
	logic prev_q;
	logic [2:0] warm_q;

	// ==========================================
	// Synchroniser and edge detect
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			prev_q <= 1'b1;
			warm_q <= 3'h0;
		end else if (i_clk_en) begin
			meta_q <= i_pin;
			sync_q <= meta_q;
			prev_q <= sync_q;
			warm_q <= {warm_q[1:0], 1'b1};
		end
	end

	// No edge until the pipe holds real pin samples, so a low pin gives no edge after reset
	assign o_edge = i_clk_en & warm_q[2] & (i_rise_sel ? (sync_q & ~prev_q) : (~sync_q & prev_q));
endmodule
`default_nettype wire

// ===== tmcap_capture.sv
// One input capture channel with high-byte read lock.
// Assumes strobes are one-cycle pulses from the register port.
`timescale 1ns/100ps
`default_nettype none
module tmcap_capture (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic i_enable,
	input wire logic i_edge,
	input wire logic [15:0] i_count,
	input wire logic i_hi_rd,
	input wire logic i_lo_rd,
	input wire logic i_lo_acc,
	input wire logic i_flags_rd,
	output logic [15:0] o_value,
	output logic o_flag
);
	logic [15:0] value_q;
	logic flag_q;
	logic lock_q;
	logic armed_q;
	logic take;

	assign take = i_enable & i_edge & ~lock_q;

	// ==========================================
	// Capture register
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			value_q <= tmcap_pkg::CAP_RESET;
		end else if (i_clk_en && take) begin
			value_q <= i_count;
		end
	end

	// ==========================================
	// Read lock between high and low byte reads
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lock_q <= 1'b0;
		end else if (i_clk_en) begin
			if (i_hi_rd) begin
				lock_q <= 1'b1;
			end else if (i_lo_rd) begin
				lock_q <= 1'b0;
			end
		end
	end

	// ==========================================
	// Flag, two-step clear, set wins
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flag_q <= 1'b0;
			armed_q <= 1'b0;
		end else if (i_clk_en) begin
			if (take) begin
				flag_q <= 1'b1;
			end else if (armed_q && i_lo_acc) begin
				flag_q <= 1'b0;
			end
			if (i_flags_rd) begin
				armed_q <= flag_q;
			end else if (i_lo_acc) begin
				armed_q <= 1'b0;
			end
		end
	end

	assign o_value = value_q;
	assign o_flag = flag_q;
endmodule
`default_nettype wire

// ===== tmcap_sva.sv
// Checker on the ports of the timer counter and capture block.
// Assumes the byte register port timing of tmcap_top; bound below.
`timescale 1ns/100ps
`default_nettype none
module tmcap_sva #(
	parameter bit REDUCED = 1'b0,
	parameter bit EXT_BONDED = 1'b1,
	parameter bit CAP2_BONDED = 1'b1
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic i_halt,
	input wire logic i_global_mask,
	input wire logic i_ext_count_pin,
	input wire logic i_capture_pin_1,
	input wire logic i_capture_pin_2,
	input wire logic o_timer_irq,
	input wire logic [15:0] o_counter_value
);
	// ==========================================
	// Bus tracking
	logic hi_a, lo_a, rd_hi, rd_lo, wr_lo, pend_q, ovf_en_q;
	logic [7:0] snap_q;
	assign hi_a = i_addr == tmcap_pkg::ADDR_CNT_HI || i_addr == tmcap_pkg::ADDR_ALT_HI;
	assign lo_a = i_addr == tmcap_pkg::ADDR_CNT_LO || i_addr == tmcap_pkg::ADDR_ALT_LO;
	assign rd_hi = i_rd && i_clk_en && hi_a;
	assign rd_lo = i_rd && i_clk_en && lo_a;
	assign wr_lo = i_wr && i_clk_en && lo_a;
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pend_q <= 1'b0;
			snap_q <= 8'h00;
		end else if (rd_hi) begin
			pend_q <= 1'b1;
			snap_q <= pend_q ? snap_q : o_counter_value[7:0];
		end else if (rd_lo) begin
			pend_q <= 1'b0;
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ovf_en_q <= 1'b0;
		end else if (i_wr && i_clk_en && i_addr == tmcap_pkg::ADDR_CTRL_ONE) begin
			ovf_en_q <= i_wdata[tmcap_pkg::CTL1_OVF_IRQ_EN];
		end
	end
	// ==========================================
	// Properties
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	property p_step;
		$changed(o_counter_value) |-> o_counter_value == $past(o_counter_value) + 16'h0001
			|| o_counter_value == tmcap_pkg::COUNT_RELOAD;
	endproperty
	a_step: assert property (p_step) else $error("count jumped");
	property p_reload;
		wr_lo |=> o_counter_value == tmcap_pkg::COUNT_RELOAD;
	endproperty
	a_reload: assert property (p_reload) else $error("no reload");
	property p_hi;
		i_rd && i_clk_en && i_addr == tmcap_pkg::ADDR_CNT_HI |=>
			o_rdata == 8'($past(o_counter_value) >> 8);
	endproperty
	a_hi: assert property (p_hi) else $error("high byte wrong");
	property p_buf;
		rd_lo && pend_q |=> o_rdata == snap_q;
	endproperty
	a_buf: assert property (p_buf) else $error("buffered low wrong");
	property p_live;
		rd_lo && !pend_q |=> o_rdata == 8'($past(o_counter_value));
	endproperty
	a_live: assert property (p_live) else $error("live low wrong");
	property p_ovf;
		$past(o_counter_value) == tmcap_pkg::COUNT_MAX && o_counter_value == 16'h0000
			&& ovf_en_q && !i_global_mask |-> o_timer_irq;
	endproperty
	a_ovf: assert property (p_ovf) else $error("wrap without request");
	property p_mask;
		i_global_mask |-> !o_timer_irq;
	endproperty
	a_mask: assert property (p_mask) else $error("request while masked");
	property p_freeze;
		(i_halt || !i_clk_en) && !i_wr |=> $stable(o_counter_value);
	endproperty
	a_freeze: assert property (p_freeze) else $error("count moved in halt");
endmodule
bind tmcap_top tmcap_sva #(
	.REDUCED(REDUCED),
	.EXT_BONDED(EXT_BONDED),
	.CAP2_BONDED(CAP2_BONDED)
) u_sva (
	.i_ref_clk(i_ref_clk),
	.i_rst_n(i_rst_n),
	.i_clk_en(i_clk_en),
	.i_addr(i_addr),
	.i_wdata(i_wdata),
	.i_wr(i_wr),
	.i_rd(i_rd),
	.o_rdata(o_rdata),
	.i_halt(i_halt),
	.i_global_mask(i_global_mask),
	.i_ext_count_pin(i_ext_count_pin),
	.i_capture_pin_1(i_capture_pin_1),
	.i_capture_pin_2(i_capture_pin_2),
	.o_timer_irq(o_timer_irq),
	.o_counter_value(o_counter_value)
);
`default_nettype wire

// ===== tmcap_pin_model.sv
// Model of the pins around the timer: external count clock and capture inputs.
// Assumes commands from the bench change just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module tmcap_pin_model (
	input wire logic i_ref_clk,
	input wire logic i_ext_run,
	input wire logic i_tgl_1,
	input wire logic i_tgl_2,
	output logic o_ext_count_pin,
	output logic o_capture_pin_1,
	output logic o_capture_pin_2
);
	logic [1:0] div_q = 2'b00;
	initial begin
		o_ext_count_pin = 1'b0;
		o_capture_pin_1 = 1'b0;
		o_capture_pin_2 = 1'b0;
	end
	// Toggle every four cycles, same-sense edges eight apart
	always @(posedge i_ref_clk) begin
		div_q <= div_q + 2'b01;
		if (i_ext_run && div_q == 2'b11) begin
			o_ext_count_pin <= !o_ext_count_pin;
		end
	end
	always @(posedge i_ref_clk) begin
		if (i_tgl_1) begin
			o_capture_pin_1 <= !o_capture_pin_1;
		end
		if (i_tgl_2) begin
			o_capture_pin_2 <= !o_capture_pin_2;
		end
	end
endmodule
`default_nettype wire

// ===== tmcap_top_tb_top.sv
// Self-checking bench for the timer counter and capture block.
// Assumes tmcap_pkg, tmcap_top, tmcap_pin_model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module tmcap_top_tb_top;
	logic clk, rst_n, clk_en, wr, rd, halt, gmask, ext_run, tgl1, tgl2, ext_pin, cap1, cap2, irq;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, rdata_r, v, h, l;
	logic [15:0] cnt, cnt_r, c, cr, cf, dv;
	int n_fail, comparisons, n_rise, n_fall;
	logic [3:0] regs [5] = '{tmcap_pkg::ADDR_FLAGS, tmcap_pkg::ADDR_CTRL_ONE,
		tmcap_pkg::ADDR_CTRL_TWO, 4'h0, 4'hF};
	tmcap_top u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_halt(halt),
		.i_global_mask(gmask), .i_ext_count_pin(ext_pin), .i_capture_pin_1(cap1),
		.i_capture_pin_2(cap2), .o_timer_irq(irq), .o_counter_value(cnt));
	tmcap_pin_model u_pins (.i_ref_clk(clk), .i_ext_run(ext_run), .i_tgl_1(tgl1),
		.i_tgl_2(tgl2), .o_ext_count_pin(ext_pin), .o_capture_pin_1(cap1),
		.o_capture_pin_2(cap2));
	// Reduced variant with the external count pin unbonded
	tmcap_top #(.REDUCED(1'b1), .EXT_BONDED(1'b0), .CAP2_BONDED(1'b1)) u_dut_red (
		.i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata_r), .i_halt(halt),
		.i_global_mask(gmask), .i_ext_count_pin(ext_pin), .i_capture_pin_1(cap1),
		.i_capture_pin_2(cap2), .o_timer_irq(), .o_counter_value(cnt_r));
	initial begin
		clk = 1'b0;
		forever #25 clk = !clk;
	end
	always @(ext_pin) begin
		if (ext_pin) n_rise++;
		else n_fall++;
	end
	// ==========================================
	// Bus and check tasks
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	function automatic logic [15:0] exp_count(input int ticks);
		return 16'(tmcap_pkg::COUNT_RELOAD + 16'(ticks));
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic pulse(input int ch, output logic [15:0] cv);
		@(posedge clk);
		if (ch == 1) tgl1 <= 1'b1;
		else tgl2 <= 1'b1;
		@(posedge clk);
		tgl1 <= 1'b0;
		tgl2 <= 1'b0;
		#1 cv = cnt;
	endtask
	task automatic wait_flag(input int b);
		logic [7:0] f;
		for (int i = 0; i < 20; i++) begin
			rd_reg(tmcap_pkg::ADDR_FLAGS, f);
			if (f[b] === 1'b1) return;
		end
		chk(1'b0, "flag timeout");
		report_and_stop();
	endtask
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(32'h82be));
		{rst_n, wr, rd, halt, gmask, ext_run, tgl1, tgl2} = '0;
		clk_en = 1'b1;
		addr = 4'h0;
		wdata = 8'h00;
		repeat (3) @(posedge clk);
		chk(cnt === tmcap_pkg::COUNT_RELOAD, "reset count");
		rst_n <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rd_reg(regs[i], v);
			chk(v === 8'h00, "reset or unmapped read");
		end
		for (int s = 0; s < 3; s++) begin
			wr_reg(tmcap_pkg::ADDR_CTRL_TWO, {4'h0, 2'(s), 2'b00});
			wr_reg(tmcap_pkg::ADDR_CNT_LO, 8'($urandom));
			cyc(64);
			dv = cnt - tmcap_pkg::COUNT_RELOAD;
			chk(dv + 16'h0001 >= 16'(32 >> s) && dv <= 16'(33 >> s), "rate");
		end
		for (int p = 0; p < 2; p++) begin
			wr_reg(tmcap_pkg::ADDR_CTRL_TWO, {4'h0, tmcap_pkg::CLK_EXT, 1'b0, 1'(p)});
			wr_reg(tmcap_pkg::ADDR_ALT_LO, 8'h00);
			n_rise = 0;
			n_fall = 0;
			ext_run <= 1'b1;
			cyc(80);
			ext_run <= 1'b0;
			cyc(6);
			chk(cnt === exp_count(p ? n_rise : n_fall), "ext");
		end
		chk(cnt_r === tmcap_pkg::COUNT_RELOAD, "unbonded pin counted");
		wr_reg(tmcap_pkg::ADDR_CTRL_TWO, 8'h00);
		wr_reg(tmcap_pkg::ADDR_CTRL_ONE, 8'h20);
		cyc(1);
		chk(irq === 1'b1, "no overflow request");
		gmask <= 1'b1;
		cyc(1);
		chk(irq === 1'b0, "masked request");
		gmask <= 1'b0;
		rd_reg(tmcap_pkg::ADDR_CNT_LO, v);
		rd_reg(tmcap_pkg::ADDR_FLAGS, v);
		chk(v[tmcap_pkg::FLG_OVF] === 1'b1, "cleared unarmed");
		rd_reg(tmcap_pkg::ADDR_ALT_HI, v);
		rd_reg(tmcap_pkg::ADDR_ALT_HI, v);
		rd_reg(tmcap_pkg::ADDR_ALT_LO, v);
		rd_reg(tmcap_pkg::ADDR_FLAGS, v);
		chk(v[tmcap_pkg::FLG_OVF] === 1'b1, "alt view cleared");
		rd_reg(tmcap_pkg::ADDR_CNT_LO, v);
		rd_reg(tmcap_pkg::ADDR_FLAGS, v);
		chk(v[tmcap_pkg::FLG_OVF] === 1'b0, "not cleared");
		wr_reg(tmcap_pkg::ADDR_CNT_LO, 8'h00);
		wait_flag(tmcap_pkg::FLG_OVF);
		wr_reg(tmcap_pkg::ADDR_CNT_LO, 8'h00);
		wr_reg(tmcap_pkg::ADDR_CTRL_ONE, 8'h82);
		pulse(1, c);
		wait_flag(tmcap_pkg::FLG_CAP1);
		chk(irq === 1'b1, "no capture request");
		rd_reg(tmcap_pkg::ADDR_CAP1_HI, h);
		pulse(1, cf);
		pulse(1, cr);
		cyc(6);
		rd_reg(tmcap_pkg::ADDR_CAP1_LO, l);
		dv = {h, l} - c;
		chk(dv <= 16'h0003, "capture one value");
		rd_reg(tmcap_pkg::ADDR_FLAGS, v);
		chk(v[tmcap_pkg::FLG_CAP1] === 1'b0, "flag not cleared");
		for (int k = 0; k < 4; k++) begin
			wr_reg(tmcap_pkg::ADDR_CTRL_TWO, {2'h0, 1'(k == 2), 1'(k == 3), 2'b00, 1'(k), 1'b0});
			cyc($urandom_range(1, 20));
			pulse(2, cr);
			cyc(12);
			pulse(2, cf);
			if (k >= 2) begin
				pulse(1, c);
				pulse(1, c);
			end
			wait_flag(tmcap_pkg::FLG_CAP2);
			rd_reg(tmcap_pkg::ADDR_FLAGS, v);
			chk(rdata_r[tmcap_pkg::FLG_CAP2] === 1'b0, "reduced channel two");
			chk(k < 2 || v[tmcap_pkg::FLG_CAP1] === 1'b0, "channel one in pulse mode");
			rd_reg(tmcap_pkg::ADDR_CAP2_HI, h);
			rd_reg(tmcap_pkg::ADDR_CAP2_LO, l);
			dv = {h, l} - (k[0] ? cr : cf);
			chk(dv <= 16'h0003, "capture two edge");
		end
		for (int m = 0; m < 2; m++) begin
			{halt, clk_en} <= m ? 2'b11 : 2'b00;
			cyc(1);
			c = cnt;
			cyc($urandom_range(5, 30));
			chk(cnt === c, "count moved");
			{halt, clk_en} <= 2'b01;
			cyc(6);
			chk(cnt !== c, "count stuck");
		end
		rst_n <= 1'b0;
		cyc(2);
		chk(cnt === tmcap_pkg::COUNT_RELOAD, "reset count again");
		rst_n <= 1'b1;
		rd_reg(tmcap_pkg::ADDR_CTRL_ONE, v);
		chk(v === 8'h00, "control after reset");
		report_and_stop();
	end
endmodule
`default_nettype wire
